// file: rtl/tdr_params.svh
// Constants shared by both ends of the tone digit readout link
`ifndef TDR_PARAMS_SVH
`define TDR_PARAMS_SVH
`define TDR_DIGIT_W 4
`define TDR_PULSES 3'h4
`define TDR_GUARD_NS 2_000
`define TDR_LINK_NS 15
`define TDR_GUARD_CYC ((`TDR_GUARD_NS + `TDR_LINK_NS - 1) / `TDR_LINK_NS)
`define TDR_GUARD_W 8
`define TDR_ACK_HALF 4'h6
`define TDR_HOST_GUARD 4'hf
`define TDR_DIGIT_RST 4'h0
`endif

// file: rtl/tdr_pkg.sv
// Types shared by both ends of the tone digit readout link
package tdr_pkg;
	typedef logic [3:0] tdr_digit_t;
	typedef enum logic {TDR_EARLY, TDR_DELAYED} tdr_variant_t;
endpackage

// file: rtl/tdr_link_if.sv
// Pins between the receiver and its controller
`timescale 1ns/10ps
interface tdr_link_if;
	logic earlyToneFlag;
	logic validatedDigitFlag;
	logic serialOutOrCadence;
	logic ack;
	logic sleepRequest;
	modport device (output earlyToneFlag, output validatedDigitFlag,
		output serialOutOrCadence, input ack, input sleepRequest);
	modport host (input earlyToneFlag, input validatedDigitFlag,
		input serialOutOrCadence, output ack, output sleepRequest);
endinterface

// file: rtl/tdr_sync2.sv
// Two-flop level synchroniser
`timescale 1ns/10ps
module tdr_sync2 (
	input wire logic clk,
	input wire logic rstn,
	input wire logic d,
	output logic q
);
	logic meta;
	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// file: rtl/tdr_receiver.sv
// Receiver end: steering flags, digit hold and serial readout
`timescale 1ns/10ps
`include "tdr_params.svh"
// Overview of operation
// RULE1 - sixteen tone pairs map to four-bit codes
// RULE2 - early flag high while tone present
// RULE3 - early flag low in sleep
// RULE4 - validated flag high after valid digit
// RULE5 - validated flag low in sleep
// RULE6 - controller guard-checks early flag itself
// RULE7 - validated flag uses internal guard timing
// RULE8 - four ack pulses read four bits
// RULE9 - first ack rise captures whole digit
// RULE10 - controller idles ack low
// RULE11 - ack reads low when undriven
// RULE12 - serial pin: digit bits else cadence
// RULE13 - cadence may toggle during digit tone
// RULE14 - sleep request forces serial pin low
// RULE15 - controller holds ack low for sleep
// RULE16 - sleep request reads low when undriven
// RULE17 - least significant bit shifted first
// RULE18 - partial readout blocks new capture
// RULE19 - extra ack edges ignored until steering rise
// RULE20 - digit selected rise one to fall four
// RULE21 - rises two to four advance bit
module tdr_receiver (
	input wire logic linkClk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire tdr_pkg::tdr_variant_t variant,
	input wire logic tonePresent,
	input wire tdr_pkg::tdr_digit_t toneDigit,
	input wire logic cadence,
	input wire logic ackPin,
	input wire logic ackDriven,
	input wire logic sleepPin,
	input wire logic sleepDriven,
	output logic earlyToneFlag,
	output logic validatedDigitFlag,
	output logic serialOutOrCadence
);
	import tdr_pkg::*;

	typedef struct packed {
		logic ackPrev;
		logic steerPrev;
		logic armed;
		logic busy;
		logic [2:0] rises;
		tdr_digit_t shift;
		logic [`TDR_GUARD_W-1:0] guard;
		logic valid;
		logic vOut;
		logic early;
		logic sdo;
	} tdr_rx_t;

	tdr_rx_t r;
	tdr_rx_t next_r;
	logic ackIn;
	logic sleepIn;
	logic steer;
	logic ackRaw;
	logic sleepRaw;
	logic toneS;
	logic cadenceS;

	////////////////////////////////////////////////////////////////////////
	// Undriven pins read low, as an internal pull-down would
	assign ackRaw = ackDriven & ackPin; // RULE11
	assign sleepRaw = sleepDriven & sleepPin; // RULE16

	// Pins arrive from other clocks; two flops before the state logic, except toneDigit, which is captured directly
	tdr_sync2 uAckSync (.clk(linkClk), .rstn(rstn), .d(ackRaw), .q(ackIn));
	tdr_sync2 uSleepSync (.clk(linkClk), .rstn(rstn), .d(sleepRaw), .q(sleepIn));
	tdr_sync2 uToneSync (.clk(linkClk), .rstn(rstn), .d(tonePresent), .q(toneS));
	tdr_sync2 uCadSync (.clk(linkClk), .rstn(rstn), .d(cadence), .q(cadenceS));

	// Steering of the selected variant
	assign steer = (variant == TDR_EARLY) ? r.early : r.valid;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_r = r;
		next_r.ackPrev = ackIn;
		next_r.steerPrev = steer;
		next_r.early = toneS & (variant == TDR_EARLY); // RULE2
		// Guard counter qualifies presence and absence alike
		if (toneS != r.valid) begin
			if (r.guard == `TDR_GUARD_W'(`TDR_GUARD_CYC)) begin
				next_r.valid = toneS; // RULE7
				next_r.guard = '0;
			end else begin
				next_r.guard = r.guard + 1'b1;
			end
		end else begin
			next_r.guard = '0;
		end
		// Steering rise rearms readout, but never mid-readout
		if (steer && !r.steerPrev && !r.busy) begin
			next_r.armed = 1'b1; // RULE19
		end
		if (ackIn && !r.ackPrev) begin
			if (r.armed && !r.busy) begin
				next_r.shift = toneDigit; // RULE9 RULE1
				next_r.busy = 1'b1; // RULE18
				next_r.rises = 3'h1;
			end else if (r.busy && r.rises != `TDR_PULSES) begin
				next_r.shift = {1'b0, r.shift[3:1]}; // RULE21 RULE17
				next_r.rises = r.rises + 3'h1;
			end
		end
		// Readout ends on the fourth falling edge
		if (!ackIn && r.ackPrev && r.busy && r.rises == `TDR_PULSES) begin
			next_r.busy = 1'b0; // RULE8
			next_r.armed = 1'b0; // RULE19
		end
		// Cadence toggling during tones is passed through as is
		next_r.sdo = next_r.busy ? next_r.shift[0] : cadenceS; // RULE12 RULE20 RULE13
		if (sleepIn) begin
			next_r.early = 1'b0; // RULE3
			next_r.valid = 1'b0; // RULE5
			next_r.sdo = 1'b0; // RULE14
			next_r.guard = '0;
		end
		// Flag pin comes straight from a flop
		next_r.vOut = next_r.valid & (variant == TDR_DELAYED); // RULE4 RULE5
	end

	always_ff @(posedge linkClk) begin
		if (!rstn) begin
			r <= '0;
		end else if (clkEn) begin
			r <= next_r;
		end
	end

	assign earlyToneFlag = r.early;
	assign validatedDigitFlag = r.vOut;
	assign serialOutOrCadence = r.sdo;
endmodule

// file: rtl/tdr_controller.sv
// Controller end: watches steering, pulses ack, assembles digit
`timescale 1ns/10ps
`include "tdr_params.svh"
module tdr_controller (
	input wire logic sysClk,
	input wire logic rstn,
	input wire logic clkEn,
	input wire logic sleepCmd,
	input wire logic steerIn,
	input wire logic serialIn,
	output logic ackOut,
	output logic sleepOut,
	output tdr_pkg::tdr_digit_t digit,
	output logic digitValid
);
	import tdr_pkg::*;

	typedef enum logic [1:0] {C_IDLE, C_GUARD, C_HIGH, C_LOW} tdr_cst_t;
	typedef struct packed {
		tdr_cst_t st;
		logic [3:0] half;
		logic [2:0] cnt;
		tdr_digit_t acc;
		logic steerPrev;
		logic ack;
		logic sleep;
		tdr_digit_t dig;
		logic dv;
	} tdr_ctl_t;

	tdr_ctl_t c;
	tdr_ctl_t next_c;
	logic steerS;
	logic serialS;

	tdr_sync2 uSteer (.clk(sysClk), .rstn(rstn), .d(steerIn), .q(steerS));
	tdr_sync2 uSerial (.clk(sysClk), .rstn(rstn), .d(serialIn), .q(serialS));

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_c = c;
		next_c.dv = 1'b0;
		next_c.steerPrev = steerS;
		next_c.half = c.half + 4'h1;
		unique case (c.st)
			C_IDLE: begin
				next_c.ack = 1'b0; // RULE10
				next_c.sleep = sleepCmd; // RULE15
				if (steerS && !c.steerPrev && !sleepCmd) begin
					next_c.st = C_GUARD;
					next_c.half = 4'h0;
					next_c.cnt = 3'h0;
				end
			end
			// Own guard check; a short tone burst is dropped
			C_GUARD: begin
				if (!steerS || sleepCmd) begin
					next_c.st = C_IDLE; // RULE6
				end else if (c.half == `TDR_HOST_GUARD) begin
					next_c.st = C_HIGH;
					next_c.ack = 1'b1;
					next_c.half = 4'h0;
				end
			end
			C_HIGH: if (c.half == `TDR_ACK_HALF) begin
				// Sample late in high phase; sync adds delay
				next_c.acc = {serialS, c.acc[3:1]};
				next_c.cnt = c.cnt + 3'h1;
				next_c.ack = 1'b0;
				next_c.half = 4'h0;
				next_c.st = C_LOW;
			end
			C_LOW: if (c.half == `TDR_ACK_HALF) begin
				next_c.half = 4'h0;
				if (c.cnt == `TDR_PULSES) begin
					next_c.st = C_IDLE;
					next_c.dig = c.acc;
					next_c.dv = 1'b1;
				end else begin
					next_c.st = C_HIGH;
					next_c.ack = 1'b1; // RULE8
				end
			end
		endcase
	end

	always_ff @(posedge sysClk) begin
		if (!rstn) begin
			c <= '{st: C_IDLE, dig: `TDR_DIGIT_RST, default: '0};
		end else if (clkEn) begin
			c <= next_c;
		end
	end

	assign ackOut = c.ack;
	assign sleepOut = c.sleep;
	assign digit = c.dig;
	assign digitValid = c.dv;
endmodule

// file: sim/tdr_link_asserts.sv
// Link protocol checker
`timescale 1ns/10ps
module tdr_link_asserts (
	input wire logic linkClk,
	input wire logic rstn,
	input wire logic earlyToneFlag,
	input wire logic validatedDigitFlag,
	input wire logic serialOutOrCadence,
	input wire logic ack,
	input wire logic sleepRequest
);
	logic [2:0] rises;
	default clocking @(posedge linkClk); endclocking
	default disable iff (!rstn);
	sequence ackHigh; ack[*3]; endsequence
	sequence ackLow; (!ack)[*3]; endsequence
	sequence asleep; sleepRequest[*4]; endsequence
	////////////////////////////////////////////////////////////
	// Saturates so a runaway ack stays caught
	always_ff @(posedge linkClk) begin
		if (!rstn || $rose(earlyToneFlag | validatedDigitFlag)) begin
			rises <= 3'h0;
		end else if ($rose(ack) && rises != 3'h7) begin
			rises <= rises + 3'h1;
		end
	end
	////////////////////////////////////////////////////////////
	chk_sleep_early: assert property (asleep |=> !earlyToneFlag)
		else $error("early flag in sleep");
	chk_sleep_valid: assert property (asleep |=> !validatedDigitFlag)
		else $error("valid flag in sleep");
	chk_sleep_serial: assert property (asleep |=> !serialOutOrCadence)
		else $error("serial high in sleep");
	chk_sleep_ack: assert property ($rose(sleepRequest) |-> !ack)
		else $error("sleep with ack high");
	chk_ack_high: assert property ($rose(ack) |-> ackHigh)
		else $error("ack high too short");
	chk_ack_low: assert property ($fell(ack) |-> ackLow)
		else $error("ack low too short");
	chk_pulse_count: assert property (rises <= 3'h4)
		else $error("over four ack pulses");
	chk_one_variant: assert property (!(earlyToneFlag && validatedDigitFlag))
		else $error("both flags high");
endmodule

// file: sim/tb_top.sv
// Bench joining receiver and controller over the link
`timescale 1ns/10ps
module tb_top;
	import tdr_pkg::*;
	logic sys_clk = 1'b0, linkClk = 1'b0, rstn = 1'b0;
	logic tonePresent = 1'b0, cadence = 1'b0, sleepCmd = 1'b0, digitValid;
	tdr_variant_t variant = TDR_EARLY;
	tdr_digit_t toneDigit = 4'h0, digit;
	int miscompares = 0, num_checks = 0, cycles = 0, seed = 61047;
	tdr_link_if link();
	always #12.5 sys_clk = ~sys_clk;
	// Odd offset keeps the clocks out of phase
	initial #3.1 forever #7.5 linkClk = ~linkClk;
	tdr_receiver u_tdr_receiver (.linkClk(linkClk), .rstn(rstn), .clkEn(1'b1),
		.variant(variant), .tonePresent(tonePresent), .toneDigit(toneDigit),
		.cadence(cadence), .ackPin(link.ack), .ackDriven(1'b1),
		.sleepPin(link.sleepRequest), .sleepDriven(1'b1),
		.earlyToneFlag(link.earlyToneFlag), .validatedDigitFlag(link.validatedDigitFlag),
		.serialOutOrCadence(link.serialOutOrCadence));
	tdr_controller u_tdr_controller (.sysClk(sys_clk), .rstn(rstn), .clkEn(1'b1),
		.sleepCmd(sleepCmd), .steerIn(link.earlyToneFlag | link.validatedDigitFlag),
		.serialIn(link.serialOutOrCadence), .ackOut(link.ack),
		.sleepOut(link.sleepRequest), .digit(digit), .digitValid(digitValid));
	tdr_link_asserts u_tdr_link_asserts (.linkClk(linkClk), .rstn(rstn),
		.earlyToneFlag(link.earlyToneFlag), .validatedDigitFlag(link.validatedDigitFlag),
		.serialOutOrCadence(link.serialOutOrCadence), .ack(link.ack),
		.sleepRequest(link.sleepRequest));
	////////////////////////////////////////////////////////////
	task automatic check(input tdr_digit_t seen, input tdr_digit_t exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			conclude();
		end
	end
	////////////////////////////////////////////////////////////
	task automatic readDigit(input tdr_variant_t v, input tdr_digit_t d);
		int n;
		variant <= v;
		toneDigit <= d;
		tonePresent <= 1'b1;
		cadence <= 1'($random(seed));
		for (n = 0; n < 2000 && link.ack !== 1'b1; n++) @(negedge sys_clk);
		repeat (3) @(posedge sys_clk);
		// Tone changes after capture must not leak in
		toneDigit <= 4'($random(seed));
		for (n = 0; n < 2000 && digitValid !== 1'b1; n++) @(negedge sys_clk);
		check(digit, d);
		@(posedge sys_clk);
		tonePresent <= 1'b0;
		repeat (300) @(posedge sys_clk);
		@(negedge sys_clk);
		check({3'h0, link.serialOutOrCadence}, {3'h0, cadence});
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 32; i++) begin
			readDigit(tdr_variant_t'(i[4]), i[3:0]);
			$display("digit test %0d done", i);
		end
		for (int v = 0; v < 2; v++) begin
			variant <= tdr_variant_t'(v[0]);
			sleepCmd <= 1'b1;
			cadence <= 1'b1;
			repeat (20) @(posedge sys_clk);
			tonePresent <= 1'b1;
			repeat (300) @(negedge sys_clk);
			check({1'b0, link.earlyToneFlag, link.validatedDigitFlag,
				link.serialOutOrCadence}, 4'h0);
			@(posedge sys_clk);
			tonePresent <= 1'b0;
			sleepCmd <= 1'b0;
			repeat (300) @(posedge sys_clk);
			$display("sleep test %0d done", v);
		end
		conclude();
	end
endmodule
